// File: rtl/csp_pkg.sv
// Constants of the cell secondary protector.
// Assumes a 20 MHz clock and an APB register bus with 32-bit data.
package csp_pkg;

	// Clock
	localparam int CLK_PERIOD_NS = 50;

	// Register byte offsets
	localparam logic [7:0] FAULT_STATUS_OFS = 8'h00;
	localparam logic [7:0] ALERT_STATUS_OFS = 8'h04;
	localparam logic [7:0] DEVICE_STATUS_OFS = 8'h08;
	localparam logic [7:0] HIGH_FLAGS_OFS = 8'h0C;
	localparam logic [7:0] LOW_FLAGS_OFS = 8'h10;
	localparam logic [7:0] OV_THRESH_OFS = 8'h14;
	localparam logic [7:0] UV_THRESH_OFS = 8'h18;
	localparam logic [7:0] OV_DELAY_OFS = 8'h1C;
	localparam logic [7:0] UV_DELAY_OFS = 8'h20;
	localparam logic [7:0] TEMP_DELAY_OFS = 8'h24;
	localparam logic [7:0] TEMP1_THRESH_OFS = 8'h28;
	localparam logic [7:0] TEMP2_THRESH_OFS = 8'h2C;
	localparam logic [7:0] FUNC_CONFIG_OFS = 8'h30;

	// Status field positions
	localparam int FLT_OV_BIT = 0;
	localparam int FLT_UV_BIT = 1;
	localparam int FORCE_BIT = 2;
	localparam int ALR_T1_BIT = 0;
	localparam int ALR_T2_BIT = 1;
	localparam int DEV_FAULT_BIT = 0;
	localparam int DEV_ALERT_BIT = 1;
	localparam int CN_LSB = 2;

	// Reset values
	localparam logic [7:0] OV_THRESH_RST = 8'h00;
	localparam logic [7:0] UV_THRESH_RST = 8'h00;
	localparam logic [7:0] DELAY_RST = 8'h00;
	localparam logic [3:0] TEMP_THRESH_RST = 4'h0;
	localparam logic [7:0] FUNC_CONFIG_RST = 8'h00;

	// Cells and comparator scaling (millivolts, ratio in 1/10000)
	localparam int NUM_CELLS = 6;
	localparam logic [15:0] OV_BASE_MV = 16'h0BB8;
	localparam logic [15:0] UV_BASE_MV = 16'h03E8;
	localparam logic [15:0] STEP_MV = 16'h0032;
	localparam logic [15:0] HYST_MV = 16'h0032;

	// Timing: delay code bit 7 picks the coarse unit
	localparam int FINE_UNIT_NS = 100000;
	localparam int FINE_CYC = (FINE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int COARSE_UNIT_US = 25000;
	localparam int COARSE_TICKS = COARSE_UNIT_US * 1000 / FINE_UNIT_NS;
	localparam int DEGLITCH_NS = 50000;
	localparam int DEGLITCH_CYC = DEGLITCH_NS / CLK_PERIOD_NS;
	localparam int BLANK_US = 200;
	localparam int BLANK_CYC = (BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLY_RANGE_BIT = 7;

	// Temperature trip ratios, set and clear
	function automatic logic [13:0] csp_ot_set(input logic [3:0] code);
		case (code)
			4'h1: csp_ot_set = 14'd2000;
			4'h2: csp_ot_set = 14'd2244;
			4'h3: csp_ot_set = 14'd2488;
			4'h4: csp_ot_set = 14'd2712;
			4'h5: csp_ot_set = 14'd2956;
			4'h6: csp_ot_set = 14'd3156;
			4'h7: csp_ot_set = 14'd3356;
			4'h8: csp_ot_set = 14'd3556;
			4'h9: csp_ot_set = 14'd3712;
			4'hA: csp_ot_set = 14'd3866;
			4'hB: csp_ot_set = 14'd4000;
			default: csp_ot_set = 14'h3FFF;
		endcase
	endfunction

	function automatic logic [13:0] csp_ot_clr(input logic [3:0] code);
		case (code)
			4'h1: csp_ot_clr = 14'd1766;
			4'h2: csp_ot_clr = 14'd2000;
			4'h3: csp_ot_clr = 14'd2270;
			4'h4: csp_ot_clr = 14'd2498;
			4'h5: csp_ot_clr = 14'd2750;
			4'h6: csp_ot_clr = 14'd2956;
			4'h7: csp_ot_clr = 14'd3162;
			4'h8: csp_ot_clr = 14'd3368;
			4'h9: csp_ot_clr = 14'd3528;
			4'hA: csp_ot_clr = 14'd3688;
			4'hB: csp_ot_clr = 14'd3824;
			default: csp_ot_clr = 14'h3FFF;
		endcase
	endfunction

endpackage

// File: rtl/csp_qual_timer.sv
// Qualification timer for one protection source.
// Assumes ticks are one-cycle pulses from the same clock.
module csp_qual_timer
	import csp_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic cond_in,
	input wire logic restart_in,
	input wire logic [7:0] delay_in,
	input wire logic fine_tick_in,
	input wire logic coarse_tick_in,
	output logic done_out
);

	localparam logic [10:0] DG_LAST = 11'(DEGLITCH_CYC);

	logic [10:0] dg_cnt_ff;
	logic [6:0] tm_cnt_ff;
	logic tick;
	logic dg_ok;

	assign tick = delay_in[DLY_RANGE_BIT] ? coarse_tick_in : fine_tick_in;
	assign dg_ok = (dg_cnt_ff == DG_LAST);

	// Deglitch ahead of the delay count
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dg_cnt_ff <= '0;
		end else if (!cond_in || restart_in) begin
			dg_cnt_ff <= '0;
		end else if (!dg_ok) begin
			dg_cnt_ff <= dg_cnt_ff + 11'h001;
		end
	end

	// Delay count in programmed units
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tm_cnt_ff <= '0;
		end else if (!cond_in || restart_in) begin
			tm_cnt_ff <= '0;
		end else if (dg_ok && tick && tm_cnt_ff != delay_in[6:0]) begin
			tm_cnt_ff <= tm_cnt_ff + 7'h01;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			done_out <= 1'b0;
		end else begin
			done_out <= cond_in && !restart_in && dg_ok &&
				(tm_cnt_ff == delay_in[6:0]) && (delay_in[6:0] != 7'h00);
		end
	end

endmodule

// File: rtl/csp_protector.sv
// Secondary protector: comparators, timers, flags, stack pins, APB regs.
// Assumes synchronous APB master and pins from outside the clock domain.
//
// Contract
// - A qualified condition sets its flag in the fault or alert status.
// - Fault flags OR to fault summary, alert flags to alert summary, pins.
// - With a nonzero delay, summaries and pins stay latched until the host clears them.
// - Separate programmable timers for overvoltage, undervoltage, overtemperature.
// - Delay zero: flag follows the live condition, no latching.
// - Writing one clears flag and pin and restarts that timer.
// - Comparators stay off about 200 us after leaving sleep.
// - Cells above the configured count are ignored for voltage checks.
// - Cell above overvoltage threshold past the delay sets its flag.
// - Cell below undervoltage threshold past the delay sets its flag.
// - Overvoltage threshold steps 50 mV; comparators have hysteresis.
// - A fixed 50 us deglitch precedes each delay timer.
// - Thermistor over threshold past delay sets its alert flag and pin.
// - Temperature code zero disables; codes one to eleven pick ratios.
// - Each thermistor input has its own threshold setting.
// - Thermistors share one delay; zero is instant and unlatched.
// - Faults signalled on dedicated pins without host action.
// - Fault or alert from the device above passes downward.
// - Base device drives host-side pins instead of downward pins.
// - Force bits written directly; other status bits clear by writing one.
//
// The register offsets and the APB register port are this design's own decisions.
module csp_protector
	import csp_pkg::*;
(
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	// APB slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Measured inputs
	input wire logic [NUM_CELLS-1:0][15:0] CELL_MV_IN,
	input wire logic [13:0] THERMISTOR_IN_A_IN,
	input wire logic [13:0] THERMISTOR_IN_B_IN,
	input wire logic SLEEP_IN,
	// Stack pins
	input wire logic BASE_N_IN,
	input wire logic FAULT_ABOVE_IN,
	input wire logic ALERT_ABOVE_IN,
	output logic FAULT_DOWN_OUT,
	output logic ALERT_DOWN_OUT,
	output logic FAULT_HOST_OUT,
	output logic ALERT_HOST_OUT
);

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	function automatic logic [NUM_CELLS-1:0] cell_mask(input logic [1:0] cn);
		case (cn)
			2'b00: cell_mask = 6'b11_1111;
			2'b01: cell_mask = 6'b01_1111;
			2'b10: cell_mask = 6'b00_1111;
			2'b11: cell_mask = 6'b00_0111;
			default: cell_mask = 6'b11_1111;
		endcase
	endfunction

	// Input synchronisers
	logic [NUM_CELLS-1:0][15:0] cell_s1_ff, cell_ff;
	logic [13:0] ts_a_s1_ff, ts_a_ff, ts_b_s1_ff, ts_b_ff;
	logic [4:0] pin_s1_ff, pin_ff;
	logic sleep_d_ff;

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			cell_s1_ff <= '0;
			cell_ff <= '0;
			ts_a_s1_ff <= '0;
			ts_a_ff <= '0;
			ts_b_s1_ff <= '0;
			ts_b_ff <= '0;
			pin_s1_ff <= '0;
			pin_ff <= '0;
		end else begin
			cell_s1_ff <= CELL_MV_IN;
			cell_ff <= cell_s1_ff;
			ts_a_s1_ff <= THERMISTOR_IN_A_IN;
			ts_a_ff <= ts_a_s1_ff;
			ts_b_s1_ff <= THERMISTOR_IN_B_IN;
			ts_b_ff <= ts_b_s1_ff;
			pin_s1_ff <= {SLEEP_IN, BASE_N_IN, FAULT_ABOVE_IN,
				ALERT_ABOVE_IN, 1'b1};
			pin_ff <= pin_s1_ff;
		end
	end

	logic sleep, base_n, fault_above, alert_above, sync_ok;
	assign sync_ok = pin_ff[0];
	assign sleep = pin_ff[4];
	assign base_n = pin_ff[3];
	assign fault_above = pin_ff[2];
	assign alert_above = pin_ff[1];

	// Configuration registers
	logic [7:0] over_voltage_threshold_ff, under_voltage_threshold_ff;
	logic [7:0] over_voltage_delay_ff, under_voltage_delay_ff;
	logic [7:0] temperature_delay_ff, func_config_ff;
	logic [3:0] temp1_threshold_ff, temp2_threshold_ff;
	logic fault_force_ff, alert_force_ff;

	logic wr_en;
	assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			over_voltage_threshold_ff <= OV_THRESH_RST;
			under_voltage_threshold_ff <= UV_THRESH_RST;
			over_voltage_delay_ff <= DELAY_RST;
			under_voltage_delay_ff <= DELAY_RST;
			temperature_delay_ff <= DELAY_RST;
			temp1_threshold_ff <= TEMP_THRESH_RST;
			temp2_threshold_ff <= TEMP_THRESH_RST;
			func_config_ff <= FUNC_CONFIG_RST;
		end else if (wr_en) begin
			if (hit(PADDR_IN, OV_THRESH_OFS))
				over_voltage_threshold_ff <= PWDATA_IN[7:0];
			if (hit(PADDR_IN, UV_THRESH_OFS))
				under_voltage_threshold_ff <= PWDATA_IN[7:0];
			if (hit(PADDR_IN, OV_DELAY_OFS))
				over_voltage_delay_ff <= PWDATA_IN[7:0];
			if (hit(PADDR_IN, UV_DELAY_OFS))
				under_voltage_delay_ff <= PWDATA_IN[7:0];
			if (hit(PADDR_IN, TEMP_DELAY_OFS))
				temperature_delay_ff <= PWDATA_IN[7:0];
			if (hit(PADDR_IN, TEMP1_THRESH_OFS))
				temp1_threshold_ff <= PWDATA_IN[3:0];
			if (hit(PADDR_IN, TEMP2_THRESH_OFS))
				temp2_threshold_ff <= PWDATA_IN[3:0];
			if (hit(PADDR_IN, FUNC_CONFIG_OFS))
				func_config_ff <= PWDATA_IN[7:0];
		end
	end

	// Force bits: written directly
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			fault_force_ff <= 1'b0;
			alert_force_ff <= 1'b0;
		end else if (wr_en) begin
			if (hit(PADDR_IN, FAULT_STATUS_OFS))
				fault_force_ff <= PWDATA_IN[FORCE_BIT];
			if (hit(PADDR_IN, ALERT_STATUS_OFS))
				alert_force_ff <= PWDATA_IN[FORCE_BIT];
		end
	end

	// Write-one clear strobes
	logic clr_ov, clr_uv, clr_t1, clr_t2;
	assign clr_ov = wr_en && hit(PADDR_IN, FAULT_STATUS_OFS) &&
		PWDATA_IN[FLT_OV_BIT];
	assign clr_uv = wr_en && hit(PADDR_IN, FAULT_STATUS_OFS) &&
		PWDATA_IN[FLT_UV_BIT];
	assign clr_t1 = wr_en && hit(PADDR_IN, ALERT_STATUS_OFS) &&
		PWDATA_IN[ALR_T1_BIT];
	assign clr_t2 = wr_en && hit(PADDR_IN, ALERT_STATUS_OFS) &&
		PWDATA_IN[ALR_T2_BIT];

	// Sleep exit blanking
	logic [12:0] blank_cnt_ff;
	logic blank;
	// Also blank until synced samples replace reset zeros
	assign blank = (blank_cnt_ff != 13'h0000) || sleep || !sync_ok;

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sleep_d_ff <= 1'b0;
			blank_cnt_ff <= '0;
		end else begin
			sleep_d_ff <= sleep;
			if (sleep || sleep_d_ff)
				blank_cnt_ff <= 13'(BLANK_CYC);
			else if (blank_cnt_ff != 13'h0000)
				blank_cnt_ff <= blank_cnt_ff - 13'h0001;
		end
	end

	// Unit ticks
	logic [10:0] fine_cnt_ff;
	logic [7:0] coarse_cnt_ff;
	logic fine_tick_ff, coarse_tick_ff;

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			fine_cnt_ff <= '0;
			coarse_cnt_ff <= '0;
			fine_tick_ff <= 1'b0;
			coarse_tick_ff <= 1'b0;
		end else begin
			fine_tick_ff <= 1'b0;
			coarse_tick_ff <= 1'b0;
			if (fine_cnt_ff == 11'(FINE_CYC - 1)) begin
				fine_cnt_ff <= '0;
				fine_tick_ff <= 1'b1;
				if (coarse_cnt_ff == 8'(COARSE_TICKS - 1)) begin
					coarse_cnt_ff <= '0;
					coarse_tick_ff <= 1'b1;
				end else begin
					coarse_cnt_ff <= coarse_cnt_ff + 8'h01;
				end
			end else begin
				fine_cnt_ff <= fine_cnt_ff + 11'h001;
			end
		end
	end

	// Voltage comparators with hysteresis
	logic [15:0] ov_trip, ov_rel, uv_trip, uv_rel;
	logic [NUM_CELLS-1:0] ov_cmp_ff, uv_cmp_ff, enabled;
	assign ov_trip = OV_BASE_MV + 16'(over_voltage_threshold_ff * STEP_MV);
	assign ov_rel = ov_trip - HYST_MV;
	assign uv_trip = UV_BASE_MV + 16'(under_voltage_threshold_ff * STEP_MV);
	assign uv_rel = uv_trip + HYST_MV;
	assign enabled = cell_mask(func_config_ff[CN_LSB+1:CN_LSB]);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CELLS; gi++) begin : g_cell
			always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
				if (!RST_N_IN) begin
					ov_cmp_ff[gi] <= 1'b0;
					uv_cmp_ff[gi] <= 1'b0;
				end else if (blank || !enabled[gi]) begin
					ov_cmp_ff[gi] <= 1'b0;
					uv_cmp_ff[gi] <= 1'b0;
				end else begin
					if (cell_ff[gi] > ov_trip)
						ov_cmp_ff[gi] <= 1'b1;
					else if (cell_ff[gi] < ov_rel)
						ov_cmp_ff[gi] <= 1'b0;
					if (cell_ff[gi] < uv_trip)
						uv_cmp_ff[gi] <= 1'b1;
					else if (cell_ff[gi] > uv_rel)
						uv_cmp_ff[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Temperature comparators
	logic t1_cmp_ff, t2_cmp_ff;

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			t1_cmp_ff <= 1'b0;
			t2_cmp_ff <= 1'b0;
		end else begin
			if (blank || temp1_threshold_ff == 4'h0)
				t1_cmp_ff <= 1'b0;
			else if (ts_a_ff > csp_ot_set(temp1_threshold_ff))
				t1_cmp_ff <= 1'b1;
			else if (ts_a_ff < csp_ot_clr(temp1_threshold_ff))
				t1_cmp_ff <= 1'b0;
			if (blank || temp2_threshold_ff == 4'h0)
				t2_cmp_ff <= 1'b0;
			else if (ts_b_ff > csp_ot_set(temp2_threshold_ff))
				t2_cmp_ff <= 1'b1;
			else if (ts_b_ff < csp_ot_clr(temp2_threshold_ff))
				t2_cmp_ff <= 1'b0;
		end
	end

	// One timer per source
	logic ov_done, uv_done, ot_done;

	csp_qual_timer u_ov_timer (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.cond_in(|ov_cmp_ff),
		.restart_in(clr_ov),
		.delay_in(over_voltage_delay_ff),
		.fine_tick_in(fine_tick_ff),
		.coarse_tick_in(coarse_tick_ff),
		.done_out(ov_done)
	);

	csp_qual_timer u_uv_timer (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.cond_in(|uv_cmp_ff),
		.restart_in(clr_uv),
		.delay_in(under_voltage_delay_ff),
		.fine_tick_in(fine_tick_ff),
		.coarse_tick_in(coarse_tick_ff),
		.done_out(uv_done)
	);

	csp_qual_timer u_ot_timer (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.cond_in(t1_cmp_ff || t2_cmp_ff),
		.restart_in(clr_t1 || clr_t2),
		.delay_in(temperature_delay_ff),
		.fine_tick_in(fine_tick_ff),
		.coarse_tick_in(coarse_tick_ff),
		.done_out(ot_done)
	);

	// Per-cell and temperature flags
	logic [NUM_CELLS-1:0] per_cell_high_flags_ff, per_cell_low_flags_ff;
	logic temp1_over_flag_ff, temp2_over_flag_ff;
	logic ov_live, uv_live, ot_live;
	assign ov_live = (over_voltage_delay_ff == DELAY_RST);
	assign uv_live = (under_voltage_delay_ff == DELAY_RST);
	assign ot_live = (temperature_delay_ff == DELAY_RST);

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			per_cell_high_flags_ff <= '0;
		end else if (ov_live) begin
			per_cell_high_flags_ff <= ov_cmp_ff;
		end else if (clr_ov) begin
			per_cell_high_flags_ff <= '0;
		end else if (ov_done) begin
			per_cell_high_flags_ff <= per_cell_high_flags_ff | ov_cmp_ff;
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			per_cell_low_flags_ff <= '0;
		end else if (uv_live) begin
			per_cell_low_flags_ff <= uv_cmp_ff;
		end else if (clr_uv) begin
			per_cell_low_flags_ff <= '0;
		end else if (uv_done) begin
			per_cell_low_flags_ff <= per_cell_low_flags_ff | uv_cmp_ff;
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			temp1_over_flag_ff <= 1'b0;
			temp2_over_flag_ff <= 1'b0;
		end else if (ot_live) begin
			temp1_over_flag_ff <= t1_cmp_ff;
			temp2_over_flag_ff <= t2_cmp_ff;
		end else begin
			if (clr_t1)
				temp1_over_flag_ff <= 1'b0;
			else if (ot_done && t1_cmp_ff)
				temp1_over_flag_ff <= 1'b1;
			if (clr_t2)
				temp2_over_flag_ff <= 1'b0;
			else if (ot_done && t2_cmp_ff)
				temp2_over_flag_ff <= 1'b1;
		end
	end

	// Summaries latch through the flags
	logic fault_sum, alert_sum;
	assign fault_sum = (|per_cell_high_flags_ff) || (|per_cell_low_flags_ff) ||
		fault_force_ff;
	assign alert_sum = temp1_over_flag_ff || temp2_over_flag_ff ||
		alert_force_ff;

	// Stack pins
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			FAULT_DOWN_OUT <= 1'b0;
			ALERT_DOWN_OUT <= 1'b0;
			FAULT_HOST_OUT <= 1'b0;
			ALERT_HOST_OUT <= 1'b0;
		end else begin
			FAULT_DOWN_OUT <= base_n && (fault_sum || fault_above);
			ALERT_DOWN_OUT <= base_n && (alert_sum || alert_above);
			FAULT_HOST_OUT <= !base_n && (fault_sum || fault_above);
			ALERT_HOST_OUT <= !base_n && (alert_sum || alert_above);
		end
	end

	// APB read side
	logic [31:0] rd_data;
	logic rd_hit;

	always_comb begin
		rd_data = '0;
		rd_hit = 1'b1;
		case (PADDR_IN)
			FAULT_STATUS_OFS: begin
				rd_data[FLT_OV_BIT] = |per_cell_high_flags_ff;
				rd_data[FLT_UV_BIT] = |per_cell_low_flags_ff;
				rd_data[FORCE_BIT] = fault_force_ff;
			end
			ALERT_STATUS_OFS: begin
				rd_data[ALR_T1_BIT] = temp1_over_flag_ff;
				rd_data[ALR_T2_BIT] = temp2_over_flag_ff;
				rd_data[FORCE_BIT] = alert_force_ff;
			end
			DEVICE_STATUS_OFS: begin
				rd_data[DEV_FAULT_BIT] = fault_sum;
				rd_data[DEV_ALERT_BIT] = alert_sum;
			end
			HIGH_FLAGS_OFS: rd_data[NUM_CELLS-1:0] = per_cell_high_flags_ff;
			LOW_FLAGS_OFS: rd_data[NUM_CELLS-1:0] = per_cell_low_flags_ff;
			OV_THRESH_OFS: rd_data[7:0] = over_voltage_threshold_ff;
			UV_THRESH_OFS: rd_data[7:0] = under_voltage_threshold_ff;
			OV_DELAY_OFS: rd_data[7:0] = over_voltage_delay_ff;
			UV_DELAY_OFS: rd_data[7:0] = under_voltage_delay_ff;
			TEMP_DELAY_OFS: rd_data[7:0] = temperature_delay_ff;
			TEMP1_THRESH_OFS: rd_data[3:0] = temp1_threshold_ff;
			TEMP2_THRESH_OFS: rd_data[3:0] = temp2_threshold_ff;
			FUNC_CONFIG_OFS: rd_data[7:0] = func_config_ff;
			default: rd_hit = 1'b0;
		endcase
	end

	// One wait state per access
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			PREADY_OUT <= 1'b0;
			PRDATA_OUT <= '0;
			PSLVERR_OUT <= 1'b0;
		end else if (PSEL_IN && PENABLE_IN && !PREADY_OUT) begin
			PREADY_OUT <= 1'b1;
			PRDATA_OUT <= PWRITE_IN ? 32'h0000_0000 : rd_data;
			PSLVERR_OUT <= !rd_hit;
		end else begin
			PREADY_OUT <= 1'b0;
			PSLVERR_OUT <= 1'b0;
		end
	end

endmodule

// File: tb/csp_stack_above.sv
// Model of the monitor stacked above: its downward fault and alert.
// Assumes requests come from the bench in the same clock domain.
module csp_stack_above (
	// Clock and requests
	input wire logic clk_in,
	input wire logic fault_req_in,
	input wire logic alert_req_in,
	// Downward levels
	output logic fault_out = 1'b0,
	output logic alert_out = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	// Registered, changes just after an edge
	always_ff @(posedge clk_in) begin
		fault_out <= fault_req_in;
		alert_out <= alert_req_in;
	end
endmodule

// File: tb/csp_protector_chk.sv
// Checker: APB handshake and stack pin relations of the protector.
// Assumes it is bound to the protector and sees its ports only.
module csp_protector_chk (
	// Clock, reset, APB
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	// Stack pins
	input wire logic BASE_N_IN,
	input wire logic FAULT_ABOVE_IN,
	input wire logic ALERT_ABOVE_IN,
	input wire logic FAULT_DOWN_OUT,
	input wire logic FAULT_HOST_OUT,
	input wire logic ALERT_HOST_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("ready held too long");
	ready_wait_a: assert property (
		PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
		else $error("no ready after one wait");
	ready_cause_a: assert property (
		PREADY_OUT |-> $past(PSEL_IN && PENABLE_IN))
		else $error("ready without access");
	err_reply_a: assert property (
		PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0000_0000)
		else $error("bad error reply");
	fault_chain_a: assert property (
		(FAULT_ABOVE_IN && BASE_N_IN) [*6] |-> FAULT_DOWN_OUT)
		else $error("fault not passed down");
	fault_host_a: assert property (
		(FAULT_ABOVE_IN && !BASE_N_IN) [*6] |-> FAULT_HOST_OUT)
		else $error("fault not sent to host");
	alert_host_a: assert property (
		(ALERT_ABOVE_IN && !BASE_N_IN) [*6] |-> ALERT_HOST_OUT)
		else $error("alert not sent to host");
	pin_excl_a: assert property (
		!(FAULT_DOWN_OUT && FAULT_HOST_OUT))
		else $error("both fault pins high");
endmodule

// File: tb/csp_protector_test.sv
// Bench: drives the protector over APB, cells, thermistors, stack.
// Assumes the checker and the stack-above model are compiled first.
module csp_protector_test
	import csp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, sleep = 1'b0, base_n = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
	logic f_req = 1'b0, a_req = 1'b0, f_above, a_above, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [NUM_CELLS-1:0][15:0] cells;
	logic [13:0] th_a = 14'h0000, th_b = 14'h0000;
	logic [3:0] pins;
	int bad_count = 0, total_checks = 0, n;
	initial begin
		forever #25 clk = ~clk;
	end
	csp_stack_above csp_stack_above_i (.clk_in(clk), .fault_req_in(f_req),
		.alert_req_in(a_req), .fault_out(f_above), .alert_out(a_above));
	csp_protector csp_protector_i (.CLK_IN(clk), .RST_N_IN(rst_n),
		.PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CELL_MV_IN(cells),
		.THERMISTOR_IN_A_IN(th_a), .THERMISTOR_IN_B_IN(th_b),
		.SLEEP_IN(sleep), .BASE_N_IN(base_n), .FAULT_ABOVE_IN(f_above),
		.ALERT_ABOVE_IN(a_above), .FAULT_DOWN_OUT(pins[0]),
		.ALERT_DOWN_OUT(pins[1]), .FAULT_HOST_OUT(pins[2]),
		.ALERT_HOST_OUT(pins[3]));
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer, called just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk(32'(pready), 32'h0000_0001);
		if (pready !== 1'b1) summarize();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask
	// Wait for a pin level, or with stay set check it holds
	task automatic pin(input int p, input logic v, input int lim,
		input logic stay);
		n = 0;
		while ((pins[p] === v) == stay && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(32'(pins[p]), 32'(v));
		if (!stay && pins[p] !== v) summarize();
	endtask
	task automatic t_regs;
		rdchk(TEMP_DELAY_OFS, 32'h0000_0000);
		rdchk(FUNC_CONFIG_OFS, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk({er, rd[30:0]}, 32'h8000_0000);
		apb(1'b1, OV_THRESH_OFS, 32'hFFFF_FF05);
		rdchk(OV_THRESH_OFS, 32'h0000_0005);
		apb(1'b1, OV_THRESH_OFS, 32'h0000_0000);
		$display("regs done");
	endtask
	task automatic t_live;
		apb(1'b1, OV_THRESH_OFS, 32'h0000_0002);
		cells[0] <= 16'h0C1C;
		pin(0, 1'b0, 30, 1'b1);
		apb(1'b1, OV_THRESH_OFS, 32'h0000_0000);
		pin(0, 1'b1, 50, 1'b0);
		rdchk(HIGH_FLAGS_OFS, 32'h0000_0001);
		cells[0] <= 16'h0BA4;
		pin(0, 1'b1, 30, 1'b1);
		cells[0] <= 16'h0B54;
		pin(0, 1'b0, 50, 1'b0);
		cells[2] <= 16'h0384;
		pin(0, 1'b1, 50, 1'b0);
		rdchk(LOW_FLAGS_OFS, 32'h0000_0004);
		rdchk(FAULT_STATUS_OFS, 32'h0000_0002);
		cells[2] <= 16'h07D0;
		pin(0, 1'b0, 50, 1'b0);
		apb(1'b1, FUNC_CONFIG_OFS, 32'h0000_0008);
		cells[4] <= 16'h0C1C;
		pin(0, 1'b0, 40, 1'b1);
		cells[3] <= 16'h0C1C;
		pin(0, 1'b1, 50, 1'b0);
		rdchk(HIGH_FLAGS_OFS, 32'h0000_0008);
		cells[3] <= 16'h07D0;
		cells[4] <= 16'h07D0;
		pin(0, 1'b0, 50, 1'b0);
		apb(1'b1, FUNC_CONFIG_OFS, 32'h0000_0000);
		$display("live done");
	endtask
	task automatic t_latch;
		apb(1'b1, OV_DELAY_OFS, 32'h0000_0001);
		cells[0] <= 16'h0C1C;
		pin(0, 1'b0, 900, 1'b1);
		cells[0] <= 16'h07D0;
		pin(0, 1'b0, 4000, 1'b1);
		cells[0] <= 16'h0C1C;
		pin(0, 1'b1, 3300, 1'b0);
		chk(32'(n > 995), 32'h0000_0001);
		apb(1'b1, FAULT_STATUS_OFS, 32'h0000_0001);
		pin(0, 1'b0, 5, 1'b0);
		pin(0, 1'b1, 3300, 1'b0);
		chk(32'(n > 995), 32'h0000_0001);
		cells[0] <= 16'h07D0;
		pin(0, 1'b1, 100, 1'b1);
		rdchk(DEVICE_STATUS_OFS, 32'h0000_0001);
		apb(1'b1, FAULT_STATUS_OFS, 32'h0000_0001);
		apb(1'b1, FAULT_STATUS_OFS, 32'h0000_0000);
		pin(0, 1'b0, 5, 1'b0);
		apb(1'b1, OV_DELAY_OFS, 32'h0000_0000);
		$display("latch done");
	endtask
	task automatic t_temp;
		apb(1'b1, TEMP1_THRESH_OFS, 32'h0000_0001);
		apb(1'b1, TEMP2_THRESH_OFS, 32'h0000_000B);
		th_a <= 14'h0834;
		th_b <= 14'h0834;
		pin(1, 1'b1, 50, 1'b0);
		rdchk(ALERT_STATUS_OFS, 32'h0000_0001);
		th_b <= 14'h1004;
		pin(1, 1'b1, 20, 1'b1);
		rdchk(ALERT_STATUS_OFS, 32'h0000_0003);
		th_a <= 14'h0000;
		th_b <= 14'h0000;
		pin(1, 1'b0, 50, 1'b0);
		$display("temp done");
	endtask
	task automatic t_stack;
		apb(1'b1, FAULT_STATUS_OFS, 32'h0000_0004);
		pin(0, 1'b1, 10, 1'b0);
		apb(1'b1, FAULT_STATUS_OFS, 32'h0000_0000);
		pin(0, 1'b0, 10, 1'b0);
		f_req <= 1'b1;
		a_req <= 1'b1;
		pin(1, 1'b1, 10, 1'b0);
		chk(32'(pins[0]), 32'h0000_0001);
		pin(1, 1'b1, 4, 1'b1);
		base_n <= 1'b0;
		pin(2, 1'b1, 10, 1'b0);
		pin(3, 1'b1, 8, 1'b1);
		chk(32'(pins[1:0]), 32'h0000_0000);
		f_req <= 1'b0;
		a_req <= 1'b0;
		pin(2, 1'b0, 10, 1'b0);
		base_n <= 1'b1;
		$display("stack done");
	endtask
	task automatic t_sleep;
		sleep <= 1'b1;
		cells[0] <= 16'h0C1C;
		pin(0, 1'b0, 30, 1'b1);
		sleep <= 1'b0;
		pin(0, 1'b1, 4300, 1'b0);
		chk(32'(n > 3900), 32'h0000_0001);
		cells[0] <= 16'h07D0;
		pin(0, 1'b0, 50, 1'b0);
		$display("sleep done");
	endtask
	initial begin
		cells = {NUM_CELLS{16'h07D0}};
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_live();
		t_latch();
		t_temp();
		t_stack();
		t_sleep();
		summarize();
	end
endmodule
bind csp_protector csp_protector_chk csp_protector_chk_i (.CLK_IN(CLK_IN),
	.RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .BASE_N_IN(BASE_N_IN),
	.FAULT_ABOVE_IN(FAULT_ABOVE_IN), .ALERT_ABOVE_IN(ALERT_ABOVE_IN),
	.FAULT_DOWN_OUT(FAULT_DOWN_OUT), .FAULT_HOST_OUT(FAULT_HOST_OUT),
	.ALERT_HOST_OUT(ALERT_HOST_OUT));
